// [pkg/brs_pkg.sv]
// Constants, register map and state types of the breaker reclose sequencer
// What this block does
// [R1] Single-pole program: three-pole first trip locks out
// [R2] Three-pole enable 30 ms after single-pole release
// [R3] Single-pole program: later attempts need three-pole initiate
// [R4] Three-pole program: single-pole first trip locks out
// [R5] Three-pole program: up to four attempts, enable always on except in mode none
// [R6] Combined program follows whichever initiate came first
// [R7] Single-pole count selects one, three or four
// [R8] Three-pole count selects one to four
// [R9] Own delay timer per single-pole attempt
// [R10] Own delay timer per three-pole attempt
// [R11] Reset interval after reclose returns to idle
// [R12] Trip in reset interval: next attempt or lockout
// [R13] Close output held for the dwell interval
// [R14] Hold wait limit expiry sends to lockout
// [R15] Closed polarity: timer runs while input open
// [R16] Open polarity: timer runs while input closed
// [R17] Sync supervision gates reclosures when enabled
// [R18] Close only within closing-angle setting
// [R19] Close only within slip setting plus angle
// [R20] Source mode: none, off, internal, external, both
// [R21] External relaying supplies both initiate inputs
// [R22] All intervals but the 30 ms quiet time counted on one 0.1 s tick
// [R23] Lockout holds until reset or mode change
package brs_pkg;
    // Clock and time base
    localparam int unsigned CLK_KHZ = 100000;
    localparam int unsigned TICK_TIME_MS = 100;
    localparam int unsigned TICK_CYCLES = TICK_TIME_MS * CLK_KHZ; // 0.1 s of core clocks
    localparam int unsigned SP_QUIET_TIME_MS = 30;
    localparam int unsigned SP_QUIET_CYCLES = SP_QUIET_TIME_MS * CLK_KHZ;
    localparam int unsigned TICK_W = 24;
    localparam int unsigned QUIET_W = 22;
    localparam int unsigned TIMER_W = 16;
    localparam int unsigned TICKS_PER_SEC = 10;

    // Register bus
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_DELAY0 = 4'h2;
    localparam logic [3:0] ADDR_RESET_IV = 4'ha;
    localparam logic [3:0] ADDR_DWELL = 4'hb;
    localparam logic [3:0] ADDR_HOLD = 4'hc;
    localparam logic [3:0] ADDR_SYNC = 4'hd;

    // Control field positions
    localparam int unsigned CTL_MODE_LSB = 0;
    localparam int unsigned CTL_PROG_LSB = 3;
    localparam int unsigned CTL_HOLD_EN = 5;
    localparam int unsigned CTL_POL = 6;
    localparam int unsigned CTL_SYNC_EN = 7;
    localparam int unsigned CTL_SPCNT_LSB = 8;
    localparam int unsigned CTL_TPCNT_LSB = 10;
    localparam int unsigned CTL_CLEAR = 15;

    // Source modes and programs
    localparam logic [2:0] MODE_NONE = 3'h0;
    localparam logic [2:0] MODE_OFF = 3'h1;
    localparam logic [2:0] MODE_INTERNAL = 3'h2;
    localparam logic [2:0] MODE_EXTERNAL = 3'h3;
    localparam logic [2:0] MODE_BOTH = 3'h4;
    localparam logic [1:0] PROG_SP = 2'h0;
    localparam logic [1:0] PROG_TP = 2'h1;
    localparam logic [1:0] PROG_COMB = 2'h2;

    // Reset values
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] DELAY_RST = 16'h000a;
    localparam logic [15:0] RESET_IV_RST = 16'h0064;
    localparam logic [15:0] DWELL_RST = 16'h0005;
    localparam logic [15:0] HOLD_RST = 16'h000a;
    localparam logic [15:0] SYNC_RST = 16'h0a14;

    typedef enum logic [2:0] {
        ST_IDLE, ST_DELAY, ST_WAIT_CLOSE, ST_CLOSE, ST_RESET_WAIT, ST_LOCKOUT
    } brs_state_type;

    // Initiates and measurements from protection logic
    typedef struct packed {
        logic int_sp;
        logic int_tp;
        logic ext_sp;
        logic ext_tp;
        logic hold_closed;
        logic volt_ok;
        logic [7:0] angle_deg;
        logic [7:0] slip_dhz;
    } brs_in_type;

    // Whole sequencer state
    typedef struct packed {
        brs_state_type st;
        logic [1:0] prog;
        logic [1:0] attempt;
        logic [TIMER_W-1:0] tmr;
        logic [TIMER_W-1:0] rst_tmr;
        logic [TICK_W-1:0] tick_cnt;
        logic tick;
        logic [QUIET_W-1:0] quiet_cnt;
        logic first_done;
        logic tp_latch;
        logic [15:0] ctrl;
        logic [7:0][15:0] delay;
        logic [15:0] reset_iv;
        logic [15:0] dwell;
        logic [15:0] hold_s;
        logic [15:0] sync_lim;
        logic close;
        logic tp_en;
        logic lockout;
        logic [15:0] rd_data;
    } brs_regs_type;
endpackage : brs_pkg

// [hdl/brs_sequencer.sv]
// Reclose sequencer with its register file and sync-check gate
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module brs_sequencer import brs_pkg::*; #(
    parameter int unsigned TICK_CYC = TICK_CYCLES,
    parameter int unsigned SP_QUIET_CYC = SP_QUIET_CYCLES
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DATA_W-1:0] rd_data_o,
    input wire logic int_sp_init_i,
    input wire logic int_tp_init_i,
    input wire logic ext_sp_init_i,
    input wire logic ext_tp_init_i,
    input wire logic hold_closed_i,
    input wire logic sync_volt_ok_i,
    input wire logic [7:0] angle_deg_i,
    input wire logic [7:0] slip_dhz_i,
    output logic close_o,
    output logic tp_trip_en_o,
    output logic lockout_o
);
    // Reset release synchroniser
    logic rst_meta_q;
    logic rst_n;
    brs_regs_type q;
    brs_regs_type d;
    brs_in_type pin;

    // Decoded settings
    logic [2:0] mode;
    logic [1:0] prog_sel;
    logic hold_en;
    logic pol_open;
    logic sync_en;
    logic [7:0] max_close_angle;
    logic [7:0] max_slip_rate;
    logic int_ok;
    logic ext_ok;
    logic sp_init;
    logic tp_init;
    logic any_init;
    logic hold_ok;
    logic sync_ok;
    logic permit;
    logic [2:0] sp_attempt_count;
    logic [2:0] tp_attempt_count;
    logic [2:0] attempt_total;
    logic last_attempt;
    logic [15:0] cur_delay;
    logic [15:0] hold_ticks;
    logic [1:0] start_prog;
    logic start_ok;
    logic ctrl_wr;
    logic mode_change;

    // Inputs travel together
    assign pin = '{int_sp: int_sp_init_i, int_tp: int_tp_init_i, ext_sp: ext_sp_init_i,
                   ext_tp: ext_tp_init_i, hold_closed: hold_closed_i, volt_ok: sync_volt_ok_i,
                   angle_deg: angle_deg_i, slip_dhz: slip_dhz_i};

    // Reset is asserted at once and released two edges later
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // Setting fields
    assign mode = q.ctrl[CTL_MODE_LSB +: 3];
    assign prog_sel = q.ctrl[CTL_PROG_LSB +: 2];
    assign hold_en = q.ctrl[CTL_HOLD_EN];
    assign pol_open = q.ctrl[CTL_POL];
    assign sync_en = q.ctrl[CTL_SYNC_EN];
    assign max_close_angle = q.sync_lim[7:0];
    assign max_slip_rate = q.sync_lim[15:8];
    assign hold_ticks = 16'(q.hold_s * TICKS_PER_SEC);

    // Source mode decides whose initiates are heard
    assign int_ok = (mode == MODE_INTERNAL) || (mode == MODE_BOTH); // [R20]
    assign ext_ok = (mode == MODE_EXTERNAL) || (mode == MODE_BOTH); // [R20]
    // Both initiate kinds come from either source
    assign sp_init = (pin.int_sp && int_ok) || (pin.ext_sp && ext_ok); // [R21]
    assign tp_init = (pin.int_tp && int_ok) || (pin.ext_tp && ext_ok); // [R21]
    assign any_init = sp_init || tp_init;

    // Attempt counts; code 3 of the single-pole field behaves as four
    always_comb begin
        unique case (q.ctrl[CTL_SPCNT_LSB +: 2])
            2'h0: sp_attempt_count = 3'h1; // [R7]
            2'h1: sp_attempt_count = 3'h3; // [R7]
            default: sp_attempt_count = 3'h4; // [R7]
        endcase
        tp_attempt_count = {1'b0, q.ctrl[CTL_TPCNT_LSB +: 2]} + 3'h1; // [R8]
        attempt_total = (q.prog == PROG_SP) ? sp_attempt_count : tp_attempt_count;
    end
    assign last_attempt = ({1'b0, q.attempt} + 3'h1) >= attempt_total; // [R12]

    // Each attempt of each program has its own delay word
    assign cur_delay = q.delay[{(q.prog == PROG_TP), q.attempt}]; // [R9] [R10]

    // Hold condition: wait timer runs while the contact is not in the wanted state or sync fails
    assign hold_ok = !hold_en || (pol_open ? !pin.hold_closed : pin.hold_closed); // [R15] [R16]
    // Angle first, slip on top of it, and the volt_ok flag from upstream must also be set
    assign sync_ok = !sync_en || ((pin.angle_deg <= max_close_angle) // [R17] [R18]
                     && (pin.slip_dhz <= max_slip_rate) && pin.volt_ok); // [R19]
    assign permit = hold_ok && sync_ok;

    // First trip picks the program; a wrong first trip is refused
    always_comb begin
        start_prog = sp_init ? PROG_SP : PROG_TP; // [R6]
        unique case (prog_sel)
            PROG_SP: start_ok = sp_init; // [R1]
            PROG_TP: start_ok = tp_init && !sp_init; // [R4]
            default: start_ok = 1'b1; // [R6]
        endcase
    end

    assign ctrl_wr = wr_i && (addr_i == ADDR_CTRL);
    assign mode_change = ctrl_wr && (wr_data_i[CTL_MODE_LSB +: 3] != mode);

    // Next state of the whole block
    always_comb begin
        d = q;
        d.tick = 1'b0;
        // Common time base; coarse 0.1 s grain keeps tmr and rst_tmr at 16 bits
        if (q.tick_cnt >= TICK_W'(TICK_CYC - 1)) begin // [R22]
            d.tick_cnt = '0;
            d.tick = 1'b1;
        end else begin
            d.tick_cnt = q.tick_cnt + TICK_W'(1);
        end
        // Quiet time since the single-pole initiate dropped, saturating
        if (sp_init) begin
            d.quiet_cnt = '0; // [R2]
        end else if (q.quiet_cnt < QUIET_W'(SP_QUIET_CYC)) begin
            d.quiet_cnt = q.quiet_cnt + QUIET_W'(1); // [R2]
        end
        // Timers advance on the tick
        if (q.tick && (q.tmr != '1)) begin
            d.tmr = q.tmr + TIMER_W'(1);
        end
        if (q.tick && (q.rst_tmr != '1)) begin
            d.rst_tmr = q.rst_tmr + TIMER_W'(1);
        end

        // Sequencer
        unique case (q.st)
            ST_IDLE: begin
                d.first_done = 1'b0;
                d.tp_latch = 1'b0;
                if (any_init) begin
                    d.prog = (prog_sel == PROG_COMB) ? start_prog : prog_sel; // [R6]
                    d.attempt = 2'h0;
                    d.tmr = '0;
                    d.st = start_ok ? ST_DELAY : ST_LOCKOUT; // [R1] [R4]
                end
            end
            ST_DELAY: begin
                // Own delay per attempt
                if (q.tmr >= cur_delay) begin // [R9] [R10]
                    d.tmr = '0;
                    d.st = ST_WAIT_CLOSE;
                end
            end
            ST_WAIT_CLOSE: begin
                if (permit) begin
                    d.tmr = '0;
                    d.rst_tmr = '0;
                    d.close = 1'b1; // [R13]
                    d.st = ST_CLOSE;
                end else if (q.tmr >= hold_ticks) begin
                    d.st = ST_LOCKOUT; // [R14]
                end else if (permit == 1'b0 && !q.tick) begin
                    d.tmr = q.tmr; // Timer only counts while close is withheld
                end
            end
            ST_CLOSE, ST_RESET_WAIT: begin
                if (q.st == ST_CLOSE) begin
                    d.first_done = 1'b1;
                end
                if (q.st == ST_CLOSE && q.tmr >= q.dwell) begin
                    d.close = 1'b0; // [R13]
                    d.st = ST_RESET_WAIT;
                end
                if (any_init) begin
                    // Trip during the reset interval
                    d.close = 1'b0;
                    d.tmr = '0;
                    if (last_attempt || !tp_init) begin
                        d.st = ST_LOCKOUT; // [R12] [R3]
                    end else begin
                        d.attempt = q.attempt + 2'h1; // [R12] [R3]
                        d.st = ST_DELAY;
                    end
                end else if (q.st == ST_RESET_WAIT && q.rst_tmr >= q.reset_iv) begin
                    d.st = ST_IDLE; // [R11]
                end
            end
            ST_LOCKOUT: begin
                // Initiates ignored here
                d.close = 1'b0; // [R23]
                d.tp_latch = 1'b0;
            end
            default: begin
                d.st = ST_LOCKOUT;
            end
        endcase

        // Single-pole program arms three-pole tripping after its first close
        if (q.prog == PROG_SP && q.first_done && (q.quiet_cnt >= QUIET_W'(SP_QUIET_CYC))
            && q.st != ST_IDLE && q.st != ST_LOCKOUT) begin
            d.tp_latch = 1'b1; // [R2]
        end

        // Register writes
        if (wr_i) begin
            unique case (addr_i)
                ADDR_CTRL: d.ctrl = {1'b0, wr_data_i[14:0]};
                ADDR_RESET_IV: d.reset_iv = wr_data_i;
                ADDR_DWELL: d.dwell = wr_data_i;
                ADDR_HOLD: d.hold_s = wr_data_i;
                ADDR_SYNC: d.sync_lim = wr_data_i;
                default: begin
                    if (addr_i >= ADDR_DELAY0 && addr_i < ADDR_RESET_IV) begin
                        d.delay[3'(addr_i - ADDR_DELAY0)] = wr_data_i;
                    end
                end
            endcase
        end
        // Clear bit or a new mode leaves lockout and abandons any cycle
        if ((ctrl_wr && wr_data_i[CTL_CLEAR]) || mode_change) begin
            d.st = ST_IDLE; // [R23]
            d.close = 1'b0;
            d.tp_latch = 1'b0;
        end

        d.lockout = (d.st == ST_LOCKOUT);
        // Off forces three-pole trips; none leaves the enable low
        if (d.ctrl[CTL_MODE_LSB +: 3] == MODE_OFF) begin
            d.tp_en = 1'b1; // [R20]
        end else if (d.ctrl[CTL_MODE_LSB +: 3] == MODE_NONE) begin
            d.tp_en = 1'b0; // [R20]
        end else begin
            d.tp_en = (d.ctrl[CTL_PROG_LSB +: 2] == PROG_TP) || d.tp_latch // [R5] [R2]
                      || (d.prog == PROG_TP && d.st != ST_IDLE && d.st != ST_LOCKOUT);
        end

        // Read data in the cycle after the strobe, zero otherwise
        d.rd_data = '0;
        if (rd_i) begin
            unique case (addr_i)
                ADDR_CTRL: d.rd_data = q.ctrl;
                ADDR_STATUS: d.rd_data = {q.lockout, q.close, q.tp_en, 6'h00,
                                          q.prog, q.attempt, q.st};
                ADDR_RESET_IV: d.rd_data = q.reset_iv;
                ADDR_DWELL: d.rd_data = q.dwell;
                ADDR_HOLD: d.rd_data = q.hold_s;
                ADDR_SYNC: d.rd_data = q.sync_lim;
                default: begin
                    if (addr_i >= ADDR_DELAY0 && addr_i < ADDR_RESET_IV) begin
                        d.rd_data = q.delay[3'(addr_i - ADDR_DELAY0)];
                    end
                end
            endcase
        end
    end

    // State register; clock enable freezes everything
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.st <= ST_IDLE;
            q.ctrl <= CTRL_RST;
            q.delay <= {8{DELAY_RST}};
            q.reset_iv <= RESET_IV_RST;
            q.dwell <= DWELL_RST;
            q.hold_s <= HOLD_RST;
            q.sync_lim <= SYNC_RST;
        end else if (ce_i) begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign rd_data_o = q.rd_data;
    assign close_o = q.close;
    assign tp_trip_en_o = q.tp_en;
    assign lockout_o = q.lockout;

    // Checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n);

    sequence s_idle_first(logic want);
        ce_i && q.st == ST_IDLE && !ctrl_wr && want;
    endsequence
    sequence s_reset_trip;
        ce_i && (q.st == ST_RESET_WAIT) && any_init && !ctrl_wr;
    endsequence

    chk_sp_wrong_first: assert property ( // [R1]
        s_idle_first(prog_sel == PROG_SP && tp_init && !sp_init) |=> lockout_o)
        else $error("three-pole first trip not locked out");
    chk_tp_wrong_first: assert property ( // [R4]
        s_idle_first(prog_sel == PROG_TP && sp_init) |=> lockout_o)
        else $error("single-pole first trip not locked out");
    chk_last_trip_lock: assert property ( // [R12]
        s_reset_trip ##0 last_attempt |=> lockout_o && !close_o)
        else $error("trip after last attempt did not lock out");
    chk_next_attempt: assert property ( // [R12]
        s_reset_trip ##0 (!last_attempt && tp_init) |=> q.st == ST_DELAY && q.attempt == $past(q.attempt) + 2'h1)
        else $error("trip in reset interval did not advance");
    chk_lockout_sticks: assert property ( // [R23]
        lockout_o && ce_i && !ctrl_wr |=> lockout_o)
        else $error("lockout left without reset");
    chk_close_angle: assert property ( // [R18]
        $rose(close_o) && sync_en |-> $past(pin.angle_deg) <= max_close_angle)
        else $error("close issued outside closing angle");
    chk_close_slip: assert property ( // [R19]
        $rose(close_o) && sync_en |-> $past(pin.slip_dhz) <= max_slip_rate && $past(q.st) == ST_WAIT_CLOSE)
        else $error("close issued outside slip limit");
    chk_hold_gate: assert property ( // [R15]
        $rose(close_o) && hold_en |-> (pol_open ? !$past(pin.hold_closed) : $past(pin.hold_closed)))
        else $error("close issued against hold input");
    chk_tp_always: assert property ( // [R5]
        ce_i && !wr_i && prog_sel == PROG_TP && mode >= MODE_INTERNAL |=> tp_trip_en_o)
        else $error("three-pole program lost trip enable");
    chk_off_mode: assert property ( // [R20]
        ce_i && !wr_i && mode == MODE_OFF |=> tp_trip_en_o && !close_o)
        else $error("off mode without three-pole trip enable");
    chk_sp_release: assert property ( // [R2]
        $rose(tp_trip_en_o) && mode >= MODE_INTERNAL && q.prog == PROG_SP && prog_sel != PROG_TP
        |-> $past(q.quiet_cnt) >= QUIET_W'(SP_QUIET_CYC))
        else $error("three-pole enable before single-pole release gap");
endmodule : brs_sequencer
`default_nettype wire

// [verification/brs_trip_model.sv]
// Behavioural protection trip logic driving the reclose initiates
`timescale 1ns/1ps
`default_nettype none
module brs_trip_model import brs_pkg::*; #(
    parameter int unsigned TRIP_CYC = 3
) (
    input wire logic core_clk_i,
    input wire logic fire_sp_i,
    input wire logic fire_tp_i,
    input wire logic use_ext_i,
    output logic int_sp_o,
    output logic int_tp_o,
    output logic ext_sp_o,
    output logic ext_tp_o
);
    // Cycles left on this trip; short so it is gone before the reclose
    logic [3:0] left_q = 4'h0;
    logic tp_q = 1'b0; // Trip is three-pole
    logic ext_q = 1'b0; // Trip comes from the external relay
    // Latch a new trip, then count its length down
    always_ff @(posedge core_clk_i) begin
        if (fire_sp_i || fire_tp_i) begin
            left_q <= 4'(TRIP_CYC);
            tp_q <= fire_tp_i;
            ext_q <= use_ext_i;
        end else if (left_q != 4'h0) begin
            left_q <= left_q - 4'h1;
        end
    end
    // Both initiate kinds from both sources, low once the trip ends
    assign int_sp_o = (left_q != 4'h0) && !tp_q && !ext_q;
    assign int_tp_o = (left_q != 4'h0) && tp_q && !ext_q;
    assign ext_sp_o = (left_q != 4'h0) && !tp_q && ext_q;
    assign ext_tp_o = (left_q != 4'h0) && tp_q && ext_q;
endmodule : brs_trip_model
`default_nettype wire

// [verification/test_brs_sequencer.sv]
// Self-checking bench for the reclose sequencer
`timescale 1ns/1ps
`default_nettype none
module test_brs_sequencer import brs_pkg::*; ();
    localparam int TK = 4; // Cycles per tick, kept short
    localparam int QC = 8; // Quiet cycles after single-pole release
    localparam int RI = 25; // Reset interval in ticks
    localparam int DW = 3; // Dwell in ticks
    logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wd = 16'h0, rdat;
    logic isp, itp, esp, etp, cls, tpe, lko, tpe_was = 1'b0;
    logic hc = 1'b0, vok = 1'b1, fsp = 1'b0, ftp = 1'b0, uext = 1'b0;
    logic [7:0] ang = 8'h0, slp = 8'h0;
    int fails = 0, num_checks = 0, t, sp_gap = 0;
    // Sync cases: volt ok, angle, slip; only the third is inside limits
    logic [16:0] sy [4] = '{{1'b0, 8'd10, 8'd5}, {1'b1, 8'd21, 8'd5}, {1'b1, 8'd20, 8'd10}, {1'b1, 8'd10, 8'd11}};
    always #5 clk = ~clk;
    brs_sequencer #(.TICK_CYC(TK), .SP_QUIET_CYC(QC)) uut (
        .core_clk_i(clk), .resetn_i(rstn), .ce_i(ce), .addr_i(addr), .wr_data_i(wd),
        .wr_i(wr), .rd_i(rd), .rd_data_o(rdat), .int_sp_init_i(isp), .int_tp_init_i(itp),
        .ext_sp_init_i(esp), .ext_tp_init_i(etp), .hold_closed_i(hc), .sync_volt_ok_i(vok),
        .angle_deg_i(ang), .slip_dhz_i(slp), .close_o(cls), .tp_trip_en_o(tpe), .lockout_o(lko));
    brs_trip_model #(.TRIP_CYC(3)) trip (
        .core_clk_i(clk), .fire_sp_i(fsp), .fire_tp_i(ftp), .use_ext_i(uext),
        .int_sp_o(isp), .int_tp_o(itp), .ext_sp_o(esp), .ext_tp_o(etp));
    // Enable must not rise within the quiet time after release
    always @(posedge clk) begin
        sp_gap <= isp ? 0 : sp_gap + 1;
        tpe_was <= tpe;
        if (tpe && !tpe_was) chk(16'(sp_gap >= QC - 1), 16'h1);
    end
    // Compare and count
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    // Verdict and end of run
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : tally_and_finish
    // One-cycle register write
    task automatic wrr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wrr
    // Read; data stands only in the next cycle
    task automatic rdc(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdat & m, e);
    endtask : rdc
    // Control word; the clear bit also drops any lockout
    task automatic setc(input logic [2:0] m, input logic [1:0] p, input logic [1:0] hs, input logic sy_en,
                        input logic [1:0] spc, input logic [1:0] tpc);
        wrr(ADDR_CTRL, {1'b1, 3'h0, tpc, spc, sy_en, hs, p, m});
    endtask : setc
    // Trip, wait bounded for close or lockout, time it and its dwell
    task automatic shot(input logic tp, input logic [1:0] e, input int d);
        int n;
        @(posedge clk);
        ftp <= tp;
        fsp <= !tp;
        @(posedge clk);
        ftp <= 1'b0;
        fsp <= 1'b0;
        #1;
        t = 0;
        while (!cls && !lko && t < 400) begin
            @(posedge clk);
            #1;
            t++;
        end
        chk({14'h0, lko, cls}, {14'h0, e});
        if (e != 2'b00 && t >= 400) tally_and_finish();
        if (d > 0) chk(16'(t >= d - TK && t <= d + 2 * TK), 16'h1);
        n = 0;
        while (cls && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (e == 2'b01) chk(16'(n >= DW * TK - TK && n <= DW * TK + TK), 16'h1);
    endtask : shot
    // Let the reset interval run out
    task automatic settle;
        repeat ((RI + 2) * TK) @(posedge clk);
    endtask : settle
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 16; i++) rdc(4'(i), (i < 2 || i > 13) ? 16'h0 : i < 10 ? DELAY_RST :
            i == 10 ? RESET_IV_RST : i == 11 ? DWELL_RST : i == 12 ? HOLD_RST : SYNC_RST, 16'hffff);
        for (int i = 0; i < 4; i++) begin
            wrr(4'(2 + i), 16'(2 + 3 * i));
            wrr(4'(6 + i), 16'(3 + 3 * i));
        end
        wrr(ADDR_RESET_IV, 16'(RI));
        wrr(ADDR_DWELL, 16'(DW));
        wrr(ADDR_HOLD, 16'h0001);
        wrr(4'he, 16'h1234);
        rdc(4'he, 16'h0, 16'hffff);
        rdc(4'h9, 16'h000c, 16'hffff);
        ce <= 1'b0;
        wrr(ADDR_DWELL, 16'h0007);
        ce <= 1'b1;
        rdc(ADDR_DWELL, 16'(DW), 16'hffff);
        chk(16'(tpe), 16'h0);
        shot(1'b1, 2'b00, 0);
        setc(MODE_OFF, PROG_TP, 2'h0, 1'b0, 2'h0, 2'h0);
        rdc(ADDR_CTRL, {11'h0, PROG_TP, MODE_OFF}, 16'hffff);
        chk(16'(tpe), 16'h1);
        shot(1'b1, 2'b00, 0);
        for (int m = 2; m < 5; m++)
            for (int e = 0; e < 2; e++) begin
                setc(3'(m), PROG_TP, 2'h0, 1'b0, 2'h0, 2'h0);
                uext <= 1'(e);
                shot(1'b1, {1'b0, m == 4 || m == 2 + e}, (m == 4 || m == 2 + e) ? 3 * TK : 0);
                settle();
            end
        uext <= 1'b0;
        for (int c = 0; c < 4; c++) begin
            setc(MODE_INTERNAL, PROG_TP, 2'h0, 1'b0, 2'h0, 2'(c));
            chk(16'(tpe), 16'h1);
            for (int k = 0; k <= c; k++) shot(1'b1, 2'b01, (3 + 3 * k) * TK);
            shot(1'b1, 2'b10, 0);
        end
        shot(1'b1, 2'b10, 0);
        repeat (8 * TK) @(posedge clk);
        chk({14'h0, lko, cls}, 16'h2);
        setc(MODE_INTERNAL, PROG_TP, 2'h0, 1'b0, 2'h0, 2'h0);
        repeat (2) @(posedge clk);
        #1;
        chk(16'(lko), 16'h0);
        shot(1'b0, 2'b10, 0);
        for (int c = 0; c < 3; c++) begin
            setc(MODE_INTERNAL, PROG_SP, 2'h0, 1'b0, 2'(c), 2'h0);
            shot(1'b1, 2'b10, 0);
            setc(MODE_INTERNAL, PROG_SP, 2'h0, 1'b0, 2'(c), 2'h0);
            shot(1'b0, 2'b01, 2 * TK);
            repeat (2 * QC) @(posedge clk);
            chk(16'(tpe), 16'h1);
            for (int k = 1; k < (c == 0 ? 1 : c + 2); k++) shot(1'b1, 2'b01, (2 + 3 * k) * TK);
            shot(1'b1, 2'b10, 0);
        end
        setc(MODE_INTERNAL, PROG_SP, 2'h0, 1'b0, 2'h0, 2'h0);
        shot(1'b0, 2'b01, 2 * TK);
        rdc(ADDR_STATUS, 16'h0004, 16'h0007);
        chk(16'(tpe), 16'h1);
        settle();
        rdc(ADDR_STATUS, 16'h0000, 16'h0007);
        chk(16'(tpe), 16'h0);
        setc(MODE_BOTH, PROG_COMB, 2'h0, 1'b0, 2'h0, 2'h0);
        shot(1'b0, 2'b01, 2 * TK);
        settle();
        shot(1'b1, 2'b01, 3 * TK);
        chk(16'(tpe), 16'h1);
        shot(1'b1, 2'b10, 0);
        for (int p = 0; p < 2; p++) begin
            setc(MODE_INTERNAL, PROG_TP, {1'(p), 1'b1}, 1'b0, 2'h0, 2'h0);
            hc <= 1'(p);
            shot(1'b1, 2'b10, 13 * TK);
            setc(MODE_INTERNAL, PROG_TP, {1'(p), 1'b1}, 1'b0, 2'h0, 2'h0);
            hc <= 1'(1 - p);
            shot(1'b1, 2'b01, 3 * TK);
            settle();
        end
        for (int i = 0; i < 4; i++) begin
            setc(MODE_INTERNAL, PROG_TP, 2'h0, 1'b1, 2'h0, 2'h0);
            {vok, ang, slp} <= sy[i];
            shot(1'b1, i == 2 ? 2'b01 : 2'b10, i == 2 ? 3 * TK : 13 * TK);
            if (i == 2) settle();
        end
        tally_and_finish();
    end
endmodule : test_brs_sequencer
`default_nettype wire
